// File: dv/pwss_master_model.sv
// Bus master model: open-drain low pulses of a chosen width.
// Assumes the bench resolves the wire from both pull-down enables.
`timescale 1ns/100ps
module pwss_master_model (
	// Clock
	input wire logic ref_clk,
	// Wire level and own pull-down
	input wire logic swd,
	output logic mst_oe
);
	initial mst_oe = 1'b0; // Released; the pull-up holds the wire high
	////////////////////////////////////////////////////////////////////
	// Wait for idle, pull low for w cycles, wait for the wire to rise
	task automatic pulse(input int w, output bit ok);
		int n;
		int g;
		n = 0;
		g = 0;
		while (n < 120 && g < 6000) begin
			@(negedge ref_clk);
			n = (swd === 1'b1) ? n + 1 : 0;
			g++;
		end
		mst_oe = 1'b1;
		repeat (w) @(negedge ref_clk);
		mst_oe = 1'b0;
		// Slave may still stretch the pulse, so wait for the rise
		while (swd !== 1'b1 && g < 9000) begin
			@(negedge ref_clk);
			g++;
		end
		ok = (n >= 120 && swd === 1'b1);
		repeat (20) @(negedge ref_clk); // Let the event land
	endtask
endmodule

// File: dv/pwss_slave_props.sv
// Checker for the single-wire slave, bound onto its top ports.
// Assumes synchronous active-high reset and a 10 MHz clock.
`timescale 1ns/100ps
module pwss_slave_props
	import pwss_pkg::*;
#(
	parameter logic [2:0] ADDR_LOW = 3'h1,
	parameter logic [2:0] ADDR_HIGH = 3'h2
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Wire and strap
	input wire logic swd_in,
	input wire logic swd_out,
	input wire logic swd_oe,
	input wire logic addr_sel,
	input wire logic [2:0] dev_addr,
	// Status
	input wire logic reply_taken,
	input wire logic attn_req,
	input wire logic attn_pending,
	input wire logic start_seen,
	input wire logic bus_reset
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic [11:0] oe_cnt, lo_cnt, hi_cnt, last_lo; // Run lengths
	////////////////////////////////////////////////////////////////////
	// Run lengths saturate, so a stuck wire cannot wrap to a legal value
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			oe_cnt <= 12'h000;
			lo_cnt <= 12'h000;
			hi_cnt <= 12'h000;
			last_lo <= 12'h000;
		end else begin
			oe_cnt <= !swd_oe ? 12'h000 : oe_cnt + 12'(oe_cnt != 12'hFFF);
			lo_cnt <= swd_in ? 12'h000 : lo_cnt + 12'(lo_cnt != 12'hFFF);
			hi_cnt <= !swd_in ? 12'h000 : hi_cnt + 12'(hi_cnt != 12'hFFF);
			if (swd_in && lo_cnt != 12'h000)
				last_lo <= lo_cnt; // Width of the pulse just ended
		end
	end
	sequence s_strap_hi;
		addr_sel [*4];
	endsequence
	sequence s_strap_lo;
		!addr_sel [*4];
	endsequence
	////////////////////////////////////////////////////////////////////
	a_od_only: assert property (!swd_out)
		else $error("wire driven high");
	a_rst_drive: assert property ($fell(rst) |-> swd_oe)
		else $error("no power-up reset drive");
	a_drive_width: assert property ($fell(swd_oe) |->
		oe_cnt inside {[12'h11B:12'h17F], 12'h672} || oe_cnt >= 12'hDD4)
		else $error("drive width off");
	a_drive_origin: assert property ($rose(swd_oe) |->
		hi_cnt >= 12'h06E || lo_cnt inside {[12'h001:12'h060]})
		else $error("drive began off window");
	a_strap_high: assert property (s_strap_hi |-> dev_addr == ADDR_HIGH)
		else $error("address not high choice");
	a_strap_low: assert property (s_strap_lo |-> dev_addr == ADDR_LOW)
		else $error("address not low choice");
	a_reply_slot: assert property (reply_taken |-> !swd_in)
		else $error("reply taken without pulse");
	a_attn_latch: assert property (attn_req |=> attn_pending)
		else $error("attention not pending");
	a_start_width: assert property (start_seen |->
		last_lo inside {[TH_START_CYC:TH_ATTN_CYC - 12'h001]})
		else $error("start flagged for wrong width");
	a_reset_width: assert property (bus_reset |->
		last_lo >= TH_RST_CYC)
		else $error("reset flagged for short pulse");
endmodule

bind pwss_slave pwss_slave_props #(
	.ADDR_LOW(ADDR_LOW),
	.ADDR_HIGH(ADDR_HIGH)
) i_props (
	.ref_clk(ref_clk), .rst(rst), .swd_in(swd_in), .swd_out(swd_out),
	.swd_oe(swd_oe), .addr_sel(addr_sel), .dev_addr(dev_addr),
	.reply_taken(reply_taken), .attn_req(attn_req),
	.attn_pending(attn_pending), .start_seen(start_seen),
	.bus_reset(bus_reset)
);

// File: dv/tb.sv
// Bench for the single-wire slave: master model, event capture, checks.
// Assumes a 10 MHz clock; the wire is resolved here from both enables.
`timescale 1ns/100ps
module tb;
	import pwss_pkg::*;
	logic ref_clk = 1'b0, rst = 1'b1, addr_sel = 1'b0, evt_ready = 1'b1;
	logic reply_arm = 1'b0, reply_bit = 1'b0, attn_req = 1'b0;
	logic swd_out, swd_oe, mst_oe, reply_taken, attn_pending, evt_own;
	logic start_seen, bus_reset, evt_room, evt_lost, evt_valid;
	logic [2:0] dev_addr, evt_kind;
	wire swd = !(swd_oe === 1'b1 || mst_oe === 1'b1); // Pull-up
	int failures = 0, total_checks = 0, n_start = 0;
	int n_rst = 0, n_reply = 0; // Reset and reply strobe counts
	logic [3:0] q[$]; // Captured events {kind, own}
	int wd[8] = '{118, 170, 354, 489, 800, 1090, 2000, 3600};
	pwss_kind_e kd[8] = '{KIND_D0, KIND_D0, KIND_D1, KIND_D1,
		KIND_START, KIND_START, KIND_ATTN, KIND_RST};
	initial forever #50 ref_clk = ~ref_clk;
	pwss_slave i_dut (.ref_clk(ref_clk), .rst(rst), .swd_in(swd),
		.swd_out(swd_out), .swd_oe(swd_oe), .addr_sel(addr_sel),
		.dev_addr(dev_addr), .reply_arm(reply_arm), .reply_bit(reply_bit),
		.reply_taken(reply_taken), .attn_req(attn_req),
		.attn_pending(attn_pending), .start_seen(start_seen),
		.bus_reset(bus_reset), .evt_room(evt_room), .evt_lost(evt_lost),
		.evt_valid(evt_valid), .evt_ready(evt_ready),
		.evt_kind(evt_kind), .evt_own(evt_own));
	pwss_master_model i_mst (.ref_clk(ref_clk), .swd(swd), .mst_oe(mst_oe));
	////////////////////////////////////////////////////////////////////
	// Capture events and strobes at the falling edge, where the
	// registered outputs have settled and the next pop is decided
	always @(negedge ref_clk) begin
		if (evt_valid === 1'b1 && evt_ready === 1'b1)
			q.push_back({evt_kind, evt_own});
		if (start_seen === 1'b1)
			n_start++;
		if (bus_reset === 1'b1)
			n_rst++;
		if (reply_taken === 1'b1)
			n_reply++;
	end
	task automatic report_and_stop();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Bounded wait for the next event, then compare it
	task automatic want(input logic [3:0] exp);
		int g;
		g = 0;
		while (q.size() == 0 && g < 5000) begin
			@(negedge ref_clk);
			g++;
		end
		if (q.size() == 0) begin
			failures++;
			report_and_stop();
		end
		chk(q.pop_front(), exp);
	endtask
	task automatic mp(input int w);
		bit ok;
		i_mst.pulse(w, ok);
		if (!ok) begin
			failures++;
			report_and_stop();
		end
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_power();
		chk({3'h0, swd_oe}, 4'h1);
		want({KIND_RST, 1'b1});
		chk({1'b0, dev_addr}, 4'h1);
		addr_sel = 1'b1;
		repeat (6) @(negedge ref_clk);
		chk({1'b0, dev_addr}, 4'h2);
		addr_sel = 1'b0;
		$display("t_power done");
	endtask
	// Edge widths of every kind, ending with a master reset
	task automatic t_kinds();
		foreach (wd[i]) begin
			mp(wd[i]);
			want({kd[i], 1'b0});
		end
		chk({3'h0, n_start == 2}, 4'h1);
		chk({3'h0, n_rst == 2}, 4'h1);
		$display("t_kinds done");
	endtask
	task automatic t_read();
		reply_arm = 1'b1;
		reply_bit = 1'b1;
		mp(150);
		want({KIND_D1, 1'b1});
		reply_bit = 1'b0;
		mp(150);
		want({KIND_D0, 1'b0});
		reply_arm = 1'b0;
		reply_bit = 1'b1;
		mp(150);
		want({KIND_D0, 1'b0});
		chk({3'h0, n_reply == 2}, 4'h1);
		$display("t_read done");
	endtask
	// Stall the drain until the queue refuses, then empty it
	task automatic t_fifo();
		evt_ready = 1'b0;
		repeat (17) mp(150);
		chk({3'h0, evt_room}, 4'h0);
		chk({3'h0, evt_lost}, 4'h1);
		evt_ready = 1'b1;
		repeat (16) want({KIND_D0, 1'b0});
		repeat (30) @(negedge ref_clk);
		chk({3'h0, q.size() == 0}, 4'h1);
		$display("t_fifo done");
	endtask
	// Attention held back until the fourteenth data bit after reset
	task automatic t_attn();
		mp(3600);
		want({KIND_RST, 1'b0});
		attn_req = 1'b1;
		@(negedge ref_clk);
		attn_req = 1'b0;
		chk({3'h0, attn_pending}, 4'h1);
		repeat (14) begin
			mp(150);
			want({KIND_D0, 1'b0});
		end
		want({KIND_ATTN, 1'b1});
		chk({3'h0, attn_pending}, 4'h0);
		$display("t_attn done");
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(negedge ref_clk);
		rst = 1'b0;
		t_power();
		t_kinds();
		t_read();
		t_fifo();
		t_attn();
		report_and_stop();
	end
endmodule

// File: inc/pwss_pkg.sv
// Constants and types for the pulse-width single-wire slave.
// Assumes a 10 MHz reference clock; all widths are counted in its cycles.
package pwss_pkg;

	// Reference clock period
	localparam int CLK_NS = 100;

	// Wire timing figures, in ns
	localparam int INACT_MIN_NS = 11000;
	localparam int MST_SHORT_MAX_NS = 17000;
	localparam int MST_LONG_MIN_NS = 35400;
	localparam int MST_LONG_MAX_NS = 48900;
	localparam int START_MIN_NS = 80000;
	localparam int START_MAX_NS = 109000;
	localparam int RD_ONE_MIN_NS = 28300;
	localparam int RD_ONE_MAX_NS = 38300;
	localparam int ATTN_NS = 165000;
	localparam int RST_MIN_NS = 354000;

	// Counter width; every count below fits
	localparam int CNT_W = 12;

	// Cycle counts derived from the figures
	localparam logic [CNT_W-1:0] INACT_CYC =
		CNT_W'((INACT_MIN_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] RD_ONE_CYC =
		CNT_W'((RD_ONE_MIN_NS + RD_ONE_MAX_NS) / 2 / CLK_NS);
	localparam logic [CNT_W-1:0] ATTN_CYC = CNT_W'(ATTN_NS / CLK_NS);
	localparam logic [CNT_W-1:0] RST_CYC =
		CNT_W'((RST_MIN_NS + CLK_NS - 1) / CLK_NS);

	// Classification thresholds, midway between neighbouring widths
	localparam logic [CNT_W-1:0] TH_D1_CYC =
		CNT_W'((MST_SHORT_MAX_NS + MST_LONG_MIN_NS) / 2 / CLK_NS);
	localparam logic [CNT_W-1:0] TH_START_CYC =
		CNT_W'((MST_LONG_MAX_NS + START_MIN_NS) / 2 / CLK_NS);
	localparam logic [CNT_W-1:0] TH_ATTN_CYC =
		CNT_W'((START_MAX_NS + ATTN_NS) / 2 / CLK_NS);
	localparam logic [CNT_W-1:0] TH_RST_CYC =
		CNT_W'((ATTN_NS + RST_MIN_NS) / 2 / CLK_NS);

	// Master data bits needed after a reset before attention may go out
	localparam logic [3:0] ATTN_GATE_BITS = 4'hE;

	// Event FIFO shape
	localparam int EVT_W = 4;
	localparam int EVT_DEPTH = 16;

	// Decoded pulse kinds
	typedef enum logic [2:0] {
		KIND_D0 = 3'b000,
		KIND_D1 = 3'b001,
		KIND_START = 3'b010,
		KIND_ATTN = 3'b011,
		KIND_RST = 3'b100
	} pwss_kind_e;

	// Own drive state
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_ONE = 2'b01,
		TX_ATTN = 2'b10,
		TX_RST = 2'b11
	} pwss_tx_e;

endpackage

// File: rtl/pwss_slave.sv
// Pulse-width single-wire slave: wire sampling, pulse classification,
// read-one reply, attention request, power-up reset and event FIFO.
// Assumes an external pull-up on the wire and a master that keeps its
// own pulse widths; the transaction framing sits above this block.
//
// Notes on behaviour
// [RL1] Idle only after high for inactive time
// [RL2] Five pulse kinds told apart by width
// [RL3] Own clock meets tolerance, no clock training
// [RL4] Master waits for idle before any bit
// [RL5] Master writes short zero, long one
// [RL6] Catch falling edge, time low period
// [RL7] Master reads with short pulse, times release
// [RL8] Read one: stretch low for read-one width
// [RL9] Long pulses never taken as data
// [RL10] Reserved reply bits go out as zero
// [RL11] Start seen anytime aborts current transaction
// [RL12] Start pulse stretched longer is not start
// [RL13] Attention starts idle or right after edge
// [RL14] Attention overrides all but reset
// [RL15] Attention stretched to reset length is reset
// [RL16] No attention before 14 master data bits
// [RL17] Drive reset pulse at power-up
// [RL18] Master issues own power-up reset
// [RL19] Attention announces fresh readout results
// [RL20] Address chosen by select pin level
// [RL21] Open-drain drive only, pull-up gives high
// [RL22] Master data widths within their windows
// [RL23] Master start width within its window
// [RL24] Read-one drive within its window
// [RL25] Reset drive at least reset width
// [RL26] Widths classified against midpoint thresholds
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////
// Event FIFO with valid/ready on both sides
module pwss_fifo #(
	parameter int W = 4,
	parameter int D = 16
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D];       // Storage
	logic [AW-1:0] wr_ptr;       // Write index
	logic [AW-1:0] rd_ptr;       // Read index
	logic [AW:0] fill;           // Words held
	logic [AW-1:0] next_wr_ptr;
	logic [AW-1:0] next_rd_ptr;
	logic [AW:0] next_fill;
	logic push;
	logic pop;

	// Honest flags from the fill count
	assign in_ready = (fill != (AW+1)'(D));
	assign out_valid = (fill != '0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointer and count update
	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_fill = fill;
		if (push) begin
			next_wr_ptr = (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
		end
		if (pop) begin
			next_rd_ptr = (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			next_fill = fill + 1'b1;
		end else if (pop && !push) begin
			next_fill = fill - 1'b1;
		end
	end

	// Register pointers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			fill <= next_fill;
		end
	end

	// Storage write; no reset needed, guarded by fill
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////
// Slave top
module pwss_slave
	import pwss_pkg::*;
#(
	parameter logic [2:0] ADDR_LOW = 3'h1,  // Address with select low
	parameter logic [2:0] ADDR_HIGH = 3'h2, // Address with select high
	parameter int FIFO_DEPTH = EVT_DEPTH
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Single data wire, open drain
	input wire logic swd_in,
	output logic swd_out,
	output logic swd_oe,
	// Address select strap
	input wire logic addr_sel,
	output logic [2:0] dev_addr,
	// Reply bit for the next read slot
	input wire logic reply_arm,
	input wire logic reply_bit,
	output logic reply_taken,
	// Attention request from the measurement side
	input wire logic attn_req,
	output logic attn_pending,
	// Transaction control
	output logic start_seen,
	output logic bus_reset,
	output logic evt_room,
	output logic evt_lost,
	// Decoded pulse stream
	output logic evt_valid,
	input wire logic evt_ready,
	output logic [2:0] evt_kind,
	output logic evt_own
);

	////////////////////////////////////////////////////////////////
	// Wire sampling
	logic swd_s1;         // First sync stage, read by swd_s2 only
	logic swd_s2;         // Synchronised level
	logic swd_s3;         // Delayed copy for edges
	logic sel_s1;         // Strap sync
	logic sel_s2;
	logic rise;           // Wire released
	logic line_low;

	// Two flops before any logic reads the pins
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			swd_s1 <= 1'b1;
			swd_s2 <= 1'b1;
			swd_s3 <= 1'b1;
			sel_s1 <= 1'b0;
			sel_s2 <= 1'b0;
		end else begin
			swd_s1 <= swd_in;
			swd_s2 <= swd_s1;
			swd_s3 <= swd_s2;
			sel_s1 <= addr_sel;
			sel_s2 <= sel_s1;
		end
	end

	assign line_low = !swd_s2;
	assign rise = swd_s2 && !swd_s3;

	// Address follows the strap level
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dev_addr <= ADDR_LOW;
		end else begin
			dev_addr <= sel_s2 ? ADDR_HIGH : ADDR_LOW; // RL20
		end
	end

	////////////////////////////////////////////////////////////////
	// Low and high period timers
	logic [CNT_W-1:0] low_cnt;
	logic [CNT_W-1:0] high_cnt;
	logic [CNT_W-1:0] next_low_cnt;
	logic [CNT_W-1:0] next_high_cnt;
	logic bus_idle;
	logic first_low;      // First sampled low cycle of a pulse

	// Saturating counts; low count held through the rising edge
	always_comb begin
		next_low_cnt = low_cnt;
		next_high_cnt = high_cnt;
		if (line_low) begin
			next_high_cnt = '0;
			if (!swd_s3 || rise) begin
				next_low_cnt = (low_cnt == '1) ? low_cnt : low_cnt + 1'b1;
			end else begin
				next_low_cnt = CNT_W'(1);
			end
		end else if (high_cnt != INACT_CYC) begin
			next_high_cnt = high_cnt + 1'b1;
		end
	end

	// Register timers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			low_cnt <= '0;
			high_cnt <= '0;
		end else begin
			low_cnt <= next_low_cnt;
			high_cnt <= next_high_cnt;
		end
	end

	assign bus_idle = !line_low && (high_cnt == INACT_CYC); // RL1
	assign first_low = line_low && swd_s3; // RL6

	////////////////////////////////////////////////////////////////
	// Pulse classification at release
	pwss_kind_e kind;

	// Thresholds sit between nominal widths; own clock tolerance is
	// absorbed by the margins, so no training is done
	always_comb begin
		if (low_cnt >= TH_RST_CYC) begin
			kind = KIND_RST; // RL15
		end else if (low_cnt >= TH_ATTN_CYC) begin
			kind = KIND_ATTN; // RL14
		end else if (low_cnt >= TH_START_CYC) begin
			kind = KIND_START; // RL12
		end else if (low_cnt >= TH_D1_CYC) begin
			kind = KIND_D1; // RL26
		end else begin
			kind = KIND_D0; // RL2 RL3 RL9
		end
	end

	////////////////////////////////////////////////////////////////
	// Own drive
	pwss_tx_e tx_state;
	pwss_tx_e next_tx_state;
	logic [CNT_W-1:0] tx_cnt;
	logic [CNT_W-1:0] next_tx_cnt;
	logic own;            // This pulse carried our drive
	logic next_own;
	logic [3:0] bit_cnt;  // Master data bits since reset
	logic [3:0] next_bit_cnt;
	logic attn_ok;
	logic go_attn;
	logic go_one;
	logic next_reply_taken;
	logic fifo_in_ready;

	// Attention only once enough bits passed and events can be stored
	assign attn_ok = attn_pending && (bit_cnt == ATTN_GATE_BITS) &&
		fifo_in_ready; // RL16
	// Send when idle, or riding the master's edge
	assign go_attn = attn_ok && (bus_idle || first_low); // RL13
	// Armed one reply; an unarmed slot returns zero
	assign go_one = first_low && reply_arm && reply_bit; // RL8 RL10

	// Drive state choice; attention beats a reply
	always_comb begin
		next_tx_state = tx_state;
		next_tx_cnt = tx_cnt;
		next_reply_taken = 1'b0;
		unique case (tx_state)
			TX_IDLE: begin
				if (go_attn) begin
					next_tx_state = TX_ATTN; // RL14
					next_tx_cnt = ATTN_CYC;
				end else if (go_one) begin
					next_tx_state = TX_ONE;
					next_tx_cnt = RD_ONE_CYC; // RL24
					next_reply_taken = 1'b1;
				end else if (first_low && reply_arm) begin
					next_reply_taken = 1'b1; // Zero reply, wire left alone
				end
			end
			TX_ONE, TX_ATTN, TX_RST: begin
				if (tx_cnt == CNT_W'(1)) begin
					next_tx_state = TX_IDLE;
				end
				next_tx_cnt = tx_cnt - 1'b1;
			end
		endcase
	end

	// Track whether we drove during this pulse
	always_comb begin
		next_own = own;
		if (rise) begin
			next_own = 1'b0;
		end else if (tx_state != TX_IDLE) begin
			next_own = 1'b1;
		end
	end

	// Register drive state; reset pulse goes out at power-up
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tx_state <= TX_RST; // RL17
			tx_cnt <= RST_CYC; // RL25
			own <= 1'b0;
			reply_taken <= 1'b0;
		end else begin
			tx_state <= next_tx_state;
			tx_cnt <= next_tx_cnt;
			own <= next_own;
			reply_taken <= next_reply_taken;
		end
	end

	// Pull low only; high comes from the pull-up
	assign swd_out = 1'b0; // RL21
	assign swd_oe = (tx_state != TX_IDLE);

	////////////////////////////////////////////////////////////////
	// Bit count, attention flag and event strobes
	logic next_attn_pending;
	logic next_start_seen;
	logic next_bus_reset;
	logic next_evt_lost;
	logic push;
	logic attn_done;

	assign push = rise;
	assign attn_done = rise && own && (kind == KIND_ATTN);

	// Master data bits counted up to the gate, cleared by any reset
	always_comb begin
		next_bit_cnt = bit_cnt;
		if (rise && kind == KIND_RST) begin
			next_bit_cnt = '0; // RL16
		end else if (rise && (kind == KIND_D0 || kind == KIND_D1) &&
				bit_cnt != ATTN_GATE_BITS) begin
			next_bit_cnt = bit_cnt + 1'b1;
		end
	end

	// Request sets win over a completed send in the same cycle
	always_comb begin
		next_attn_pending = attn_pending;
		if (attn_req) begin
			next_attn_pending = 1'b1; // RL19
		end else if (attn_done) begin
			next_attn_pending = 1'b0;
		end
		next_start_seen = rise && (kind == KIND_START); // RL11
		next_bus_reset = rise && (kind == KIND_RST);
		next_evt_lost = evt_lost || (push && !fifo_in_ready);
	end

	// Register flags; bit count starts blocked as after a reset
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bit_cnt <= '0;
			attn_pending <= 1'b0;
			start_seen <= 1'b0;
			bus_reset <= 1'b0;
			evt_lost <= 1'b0;
		end else begin
			bit_cnt <= next_bit_cnt;
			attn_pending <= next_attn_pending;
			start_seen <= next_start_seen;
			bus_reset <= next_bus_reset;
			evt_lost <= next_evt_lost;
		end
	end

	assign evt_room = fifo_in_ready;

	////////////////////////////////////////////////////////////////
	// Event FIFO; when full, attention is held back and pulses are lost
	logic [EVT_W-1:0] evt_word;

	pwss_fifo #(
		.W(EVT_W),
		.D(FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.rst(rst),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data({kind, own}),
		.out_valid(evt_valid),
		.out_ready(evt_ready),
		.out_data(evt_word)
	);

	assign evt_kind = evt_word[3:1];
	assign evt_own = evt_word[0];

endmodule
